/* File: src/swc_pkg.sv */
package swc_pkg;
   // Reset control register layout
   localparam int PD_BIT = 3;
   localparam int TO_BIT = 4;
   localparam logic [7:0] RESET_CONTROL_REG_RESET = 8'h18;
   // Peripheral wake sources
   localparam int NUM_PERIPH = 12;
   localparam int PER_TIMER_ONE = 1;
   localparam int PER_TIMER_THREE = 2;
   localparam int PER_SPEC = 4;
   // Status and mask layout: 0 sleep entered, 1 interrupt wake, 2 watchdog wake, 3 reset wake
   localparam int NUM_EVT = 4;
   // Bus offsets, one aligned word each
   localparam logic [4:0] ADDR_STATUS = 5'h00;
   localparam logic [4:0] ADDR_MASK = 5'h04;
   localparam logic [4:0] ADDR_RESET_CONTROL_REG = 5'h08;
   localparam logic [4:0] ADDR_STATE = 5'h0c;
   localparam logic [4:0] ADDR_WDT_EN = 5'h10;
   // Oscillator restart settling before the core resumes
   localparam int OSC_SETTLE_NS = 40;
   localparam int CLK_PERIOD_NS = 4;
   localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PC_STEP = 2;
   typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_WAKE} swc_state_t;
endpackage : swc_pkg

/* File: src/swc_sleep_ctrl.sv */
`timescale 1ns/10ps
// Function
// - Power-down is entered only by executing the sleep instruction.
// - Sleep entry clears the watchdog without stopping it, clears powerdown_flag, sets timeout_flag and stops the oscillator.
// - I/O drive state is frozen at its pre-sleep value for the whole sleep.
// - Wake comes from the reset pin, an enabled watchdog time-out, or an interrupt from pin, port B change or peripheral.
// - Only the twelve listed peripheral sources may wake the device.
// - A timer interrupt wakes only while that timer counts asynchronously on an external clock.
// - Peripherals needing on-chip clocks cannot wake the device.
// - A reset pin event in sleep resets the device; all other wakes resume execution.
// - powerdown_flag is set at power-up and cleared on each sleep.
// - timeout_flag is cleared when a watchdog time-out wakes the device.
// - During the sleep instruction the next instruction, two bytes on, is prefetched.
// - An interrupt wakes only if individually enabled, regardless of global_irq_enable.
// - After an interrupt wake the next instruction runs, then the vector is taken if global_irq_enable is set.
// - An enabled interrupt pending before sleep turns sleep into a no-operation with no flag or watchdog change.
// - An interrupt arising during or after sleep lets sleep complete fully and then wakes at once.
// - A watchdog time-out during sleep wakes the device rather than resetting it.
module swc_sleep_ctrl
   import swc_pkg::*;
#(
   parameter int NPER = NUM_PERIPH
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Core sequencer
   input wire logic sleep_exec,
   input wire logic [15:0] sleep_pc,
   input wire logic global_irq_enable,
   output logic [15:0] prefetch_addr_reg,
   output logic prefetch_req_reg,
   output logic core_run_reg,
   output logic vector_req_reg,
   output logic osc_drive_en_reg,
   output logic watchdog_clear_reg,
   output logic device_reset_reg,
   // Wake sources from pins and peripherals
   input wire logic master_clear_pin_n,
   input wire logic watchdog_timeout,
   input wire logic int_pin_flag,
   input wire logic int_pin_en,
   input wire logic port_b_change_flag,
   input wire logic port_b_change_en,
   input wire logic [NPER-1:0] periph_flag,
   input wire logic [NPER-1:0] periph_en,
   input wire logic timer_one_async,
   input wire logic timer_three_async,
   // I/O port drive
   input wire logic [7:0] port_out,
   input wire logic [7:0] port_oe,
   output logic [7:0] port_out_reg,
   output logic [7:0] port_oe_reg,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Interrupt
   output logic irq_reg
);
   initial begin
      if (NPER != NUM_PERIPH) $error("swc_sleep_ctrl: NPER must be twelve");
   end

   logic master_clear_pin_s1, master_clear_pin_s2, wdt_s1, wdt_s2, intp_s1, intp_s2, rb_s1, rb_s2;
   logic [NPER-1:0] per_s1, per_s2;
   swc_state_t state_reg;
   logic [7:0] reset_control_reg_reg;
   logic [NUM_EVT-1:0] status_reg, mask_reg, evt;
   logic wdt_en_reg;
   logic [$clog2(OSC_SETTLE_CYC+1)-1:0] settle_reg;
   logic irq_wake_pend;
   logic [NPER-1:0] per_allowed;
   logic irq_pending, master_clear_pin_evt, ack_reg;
   logic [31:0] rdata_next;

   // Pins and asynchronous peripheral requests are foreign to sys_clk
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         {master_clear_pin_s1, master_clear_pin_s2, wdt_s1, wdt_s2} <= 4'hf & 4'hc;
         {intp_s1, intp_s2, rb_s1, rb_s2} <= 4'h0;
         per_s1 <= '0;
         per_s2 <= '0;
      end else begin
         master_clear_pin_s1 <= ~master_clear_pin_n;
         master_clear_pin_s2 <= master_clear_pin_s1;
         wdt_s1 <= watchdog_timeout;
         wdt_s2 <= wdt_s1;
         intp_s1 <= int_pin_flag;
         intp_s2 <= intp_s1;
         rb_s1 <= port_b_change_flag;
         rb_s2 <= rb_s1;
         per_s1 <= periph_flag;
         per_s2 <= per_s1;
      end
   end

   // Timers only wake when counting on their own external clock
   always_comb begin
      per_allowed = {NPER{1'b1}};
      per_allowed[PER_TIMER_ONE] = timer_one_async;
      per_allowed[PER_SPEC] = timer_one_async;
      per_allowed[PER_TIMER_THREE] = timer_three_async;
   end

   // Enable bits alone gate wake; global enable only steers the vector
   assign irq_pending = (intp_s2 & int_pin_en) | (rb_s2 & port_b_change_en) |
                        |(per_s2 & periph_en & per_allowed);
   assign master_clear_pin_evt = master_clear_pin_s2;
   assign irq_wake_pend = irq_pending;

   // Power state sequencing
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= SWC_RUN;
         osc_drive_en_reg <= 1'b1;
         core_run_reg <= 1'b1;
         watchdog_clear_reg <= 1'b0;
         device_reset_reg <= 1'b0;
         vector_req_reg <= 1'b0;
         prefetch_req_reg <= 1'b0;
         prefetch_addr_reg <= 16'h0000;
         settle_reg <= '0;
      end else begin
         watchdog_clear_reg <= 1'b0;
         device_reset_reg <= 1'b0;
         vector_req_reg <= 1'b0;
         prefetch_req_reg <= 1'b0;
         case (state_reg)
            SWC_RUN: begin
               if (sleep_exec) begin
                  prefetch_addr_reg <= sleep_pc + 16'(PC_STEP);
                  prefetch_req_reg <= 1'b1;
                  if (!irq_pending) begin
                     watchdog_clear_reg <= 1'b1;
                     osc_drive_en_reg <= 1'b0;
                     core_run_reg <= 1'b0;
                     state_reg <= SWC_SLEEP;
                  end
               end
            end
            SWC_SLEEP: begin
               if (master_clear_pin_evt) begin
                  device_reset_reg <= 1'b1;
                  osc_drive_en_reg <= 1'b1;
                  core_run_reg <= 1'b1;
                  state_reg <= SWC_RUN;
               end else if (irq_wake_pend || (wdt_s2 && wdt_en_reg)) begin
                  osc_drive_en_reg <= 1'b1;
                  settle_reg <= '0;
                  state_reg <= SWC_WAKE;
               end
            end
            SWC_WAKE: begin
               if (settle_reg == ($bits(settle_reg))'(OSC_SETTLE_CYC - 1)) begin
                  core_run_reg <= 1'b1;
                  vector_req_reg <= global_irq_enable & irq_pending;
                  state_reg <= SWC_RUN;
               end else begin
                  settle_reg <= settle_reg + 1'b1;
               end
            end
            default: state_reg <= SWC_RUN;
         endcase
      end
   end

   // Reset control flags; power-up value has powerdown and timeout set
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reset_control_reg_reg <= RESET_CONTROL_REG_RESET;
      end else if (state_reg == SWC_RUN && sleep_exec && !irq_pending) begin
         reset_control_reg_reg[PD_BIT] <= 1'b0;
         reset_control_reg_reg[TO_BIT] <= 1'b1;
      end else if (state_reg == SWC_SLEEP && !master_clear_pin_evt && !irq_wake_pend && wdt_s2 && wdt_en_reg) begin
         reset_control_reg_reg[TO_BIT] <= 1'b0;
      end
   end

   // Port drive frozen while the core is stopped
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         port_out_reg <= 8'h00;
         port_oe_reg <= 8'h00;
      end else if (state_reg == SWC_RUN && !(sleep_exec && !irq_pending)) begin
         port_out_reg <= port_out;
         port_oe_reg <= port_oe;
      end
   end

   // Sticky events
   always_comb begin
      evt = '0;
      evt[0] = state_reg == SWC_RUN && sleep_exec && !irq_pending;
      evt[1] = state_reg == SWC_SLEEP && !master_clear_pin_evt && irq_wake_pend;
      evt[2] = state_reg == SWC_SLEEP && !master_clear_pin_evt && !irq_wake_pend && wdt_s2 && wdt_en_reg;
      evt[3] = state_reg == SWC_SLEEP && master_clear_pin_evt;
   end

   // Registers answer one cycle after the request; a set beats a clear
   always_comb begin
      case (avs_address)
         ADDR_STATUS: rdata_next = 32'(status_reg);
         ADDR_MASK: rdata_next = 32'(mask_reg);
         ADDR_RESET_CONTROL_REG: rdata_next = 32'(reset_control_reg_reg);
         ADDR_STATE: rdata_next = {29'h0, core_run_reg, osc_drive_en_reg, state_reg == SWC_SLEEP};
         ADDR_WDT_EN: rdata_next = {31'h0, wdt_en_reg};
         default: rdata_next = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
         avs_readdata <= 32'h0;
         status_reg <= '0;
         mask_reg <= '0;
         wdt_en_reg <= 1'b1;
         irq_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
         if (avs_read && !ack_reg) avs_readdata <= rdata_next;
         if (avs_write && !ack_reg && avs_address == ADDR_STATUS) begin
            status_reg <= (status_reg & ~avs_writedata[NUM_EVT-1:0]) | evt;
         end else begin
            status_reg <= status_reg | evt;
         end
         if (avs_write && !ack_reg && avs_address == ADDR_MASK) mask_reg <= avs_writedata[NUM_EVT-1:0];
         if (avs_write && !ack_reg && avs_address == ADDR_WDT_EN) wdt_en_reg <= avs_writedata[0];
         irq_reg <= |(status_reg & mask_reg);
      end
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

   // Checks
   property p_nop_sleep;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_RUN && sleep_exec && irq_pending |=> state_reg == SWC_RUN && !watchdog_clear_reg;
   endproperty
   a_nop_sleep: assert property (p_nop_sleep) else $error("pending interrupt did not make sleep a no-op");

   property p_entry;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_RUN && sleep_exec && !irq_pending |=> !osc_drive_en_reg && watchdog_clear_reg
      && !reset_control_reg_reg[PD_BIT] && reset_control_reg_reg[TO_BIT];
   endproperty
   a_entry: assert property (p_entry) else $error("sleep entry effects missing");

   property p_prefetch;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_RUN && sleep_exec |=> prefetch_addr_reg == $past(sleep_pc) + 16'h0002;
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("wrong prefetch address");

   property p_reset_wake;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_SLEEP && master_clear_pin_evt |=> device_reset_reg;
   endproperty
   a_reset_wake: assert property (p_reset_wake) else $error("reset pin did not reset");

   property p_wdt_wake;
      @(posedge sys_clk) disable iff (!arst_n)
      evt[2] |=> !reset_control_reg_reg[TO_BIT] && !device_reset_reg ##[1:20] core_run_reg;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

   property p_osc_first;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(core_run_reg) && !device_reset_reg |-> $past(osc_drive_en_reg);
   endproperty
   a_osc_first: assert property (p_osc_first) else $error("core resumed before oscillator");

   property p_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_SLEEP |=> $stable(port_out_reg) && $stable(port_oe_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("port drive changed in sleep");

   property p_only_instr;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_RUN && !sleep_exec |=> state_reg != SWC_SLEEP;
   endproperty
   a_only_instr: assert property (p_only_instr) else $error("sleep without instruction");

   property p_osc_off_sleep;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_SLEEP |-> !osc_drive_en_reg && !core_run_reg;
   endproperty
   a_osc_off_sleep: assert property (p_osc_off_sleep) else $error("oscillator or core running in sleep");

   property p_pd_no_set;
      @(posedge sys_clk) disable iff (!arst_n)
      1'b1 |=> !$rose(reset_control_reg_reg[PD_BIT]);
   endproperty
   a_pd_no_set: assert property (p_pd_no_set) else $error("powerdown flag set outside power-up");

   property p_irq_wake;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_SLEEP && !master_clear_pin_evt && irq_wake_pend |=> state_reg == SWC_WAKE && osc_drive_en_reg;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("enabled interrupt did not wake");

   property p_no_reset_other;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_SLEEP && !master_clear_pin_evt |=> !device_reset_reg;
   endproperty
   a_no_reset_other: assert property (p_no_reset_other) else $error("reset without reset pin");

   property p_no_vector;
      @(posedge sys_clk) disable iff (!arst_n)
      !global_irq_enable |=> !vector_req_reg;
   endproperty
   a_no_vector: assert property (p_no_vector) else $error("vector taken with global enable clear");

   property p_settle_stop;
      @(posedge sys_clk) disable iff (!arst_n)
      state_reg == SWC_WAKE |-> !core_run_reg;
   endproperty
   a_settle_stop: assert property (p_settle_stop) else $error("core running while oscillator settles");

   property p_status_set;
      @(posedge sys_clk) disable iff (!arst_n)
      evt[0] |=> status_reg[0];
   endproperty
   a_status_set: assert property (p_status_set) else $error("sleep event lost against clear");

   property p_irq_level;
      @(posedge sys_clk) disable iff (!arst_n)
      (|(status_reg & mask_reg)) |=> irq_reg;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt output low with unmasked status");

   property p_wait_state;
      @(posedge sys_clk) disable iff (!arst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_state: assert property (p_wait_state) else $error("more than one wait state");

   c_nop: cover property (@(posedge sys_clk) state_reg == SWC_RUN && sleep_exec && irq_pending);
   c_irq: cover property (@(posedge sys_clk) evt[1]);
   c_wdt: cover property (@(posedge sys_clk) evt[2]);
   c_master_clear_pin: cover property (@(posedge sys_clk) evt[3]);
endmodule : swc_sleep_ctrl

/* File: sim/swc_wdt_model.sv */
`timescale 1ns/10ps
module swc_wdt_model #(
   parameter int LIMIT = 60
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Enable from bench, clear from block
   input wire logic run,
   input wire logic clear,
   output logic timeout
);
   logic [15:0] count_reg;
   // Own oscillator keeps counting in sleep; only a clear or disable restarts it
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= 16'h0;
      end else if (clear || !run) begin
         count_reg <= 16'h0;
      end else if (count_reg != 16'(LIMIT)) begin
         count_reg <= count_reg + 16'h1;
      end
   end
   assign timeout = run && (count_reg == 16'(LIMIT));
endmodule : swc_wdt_model

/* File: sim/sleep_wakeup_control_tb_top.sv */
`timescale 1ns/10ps
module sleep_wakeup_control_tb_top;
   import swc_pkg::*;
   logic sys_clk, arst_n, sleep_exec, global_irq_enable, prefetch_req_reg, core_run_reg, vector_req_reg;
   logic osc_drive_en_reg, watchdog_clear_reg, device_reset_reg, master_clear_pin_n, watchdog_timeout;
   logic int_pin_flag, int_pin_en, port_b_change_flag, port_b_change_en, timer_one_async, timer_three_async;
   logic avs_read, avs_write, avs_waitrequest, irq_reg, wdt_run;
   logic [15:0] sleep_pc, prefetch_addr_reg, rnd, pc, pf_addr;
   logic [NUM_PERIPH-1:0] periph_flag, periph_en;
   logic [7:0] port_out, port_oe, port_out_reg, port_oe_reg;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   int failures, compares, n_vec, n_wdc, n_rst, v, w;
   swc_sleep_ctrl #(.NPER(NUM_PERIPH)) swc_sleep_ctrl_i (.sys_clk(sys_clk), .arst_n(arst_n),
      .sleep_exec(sleep_exec), .sleep_pc(sleep_pc), .global_irq_enable(global_irq_enable),
      .prefetch_addr_reg(prefetch_addr_reg), .prefetch_req_reg(prefetch_req_reg), .core_run_reg(core_run_reg),
      .vector_req_reg(vector_req_reg), .osc_drive_en_reg(osc_drive_en_reg), .watchdog_clear_reg(watchdog_clear_reg),
      .device_reset_reg(device_reset_reg), .master_clear_pin_n(master_clear_pin_n),
      .watchdog_timeout(watchdog_timeout), .int_pin_flag(int_pin_flag), .int_pin_en(int_pin_en),
      .port_b_change_flag(port_b_change_flag), .port_b_change_en(port_b_change_en), .periph_flag(periph_flag),
      .periph_en(periph_en), .timer_one_async(timer_one_async), .timer_three_async(timer_three_async),
      .port_out(port_out), .port_oe(port_oe), .port_out_reg(port_out_reg), .port_oe_reg(port_oe_reg),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_reg(irq_reg));
   swc_wdt_model #(.LIMIT(60)) swc_wdt_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .run(wdt_run),
      .clear(watchdog_clear_reg), .timeout(watchdog_timeout));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Pulses are counted so that checks can be made long after they went by
   always @(posedge sys_clk) begin
      if (vector_req_reg === 1'b1) n_vec++;
      if (watchdog_clear_reg === 1'b1) n_wdc++;
      if (device_reset_reg === 1'b1) n_rst++;
      if (prefetch_req_reg === 1'b1) pf_addr = prefetch_addr_reg;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task end_of_test;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   task give_up;
      failures++;
      end_of_test;
   endtask : give_up
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) give_up;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task sleep_go(input logic [15:0] a);
      @(posedge sys_clk);
      sleep_exec <= 1'b1;
      sleep_pc <= a;
      @(posedge sys_clk);
      sleep_exec <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : sleep_go
   task wake_chk;
      int n;
      n = 0;
      while (osc_drive_en_reg !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 200) give_up;
      n = 0;
      while (core_run_reg !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 200) give_up;
      chk("settle", OSC_SETTLE_CYC, n);
   endtask : wake_chk
   initial begin
      {sleep_exec, global_irq_enable, int_pin_flag, port_b_change_flag, timer_one_async} = 5'h00;
      {timer_three_async, avs_read, avs_write, wdt_run, arst_n} = 5'h00;
      {master_clear_pin_n, int_pin_en, port_b_change_en} = 3'h7;
      {sleep_pc, port_out, port_oe, avs_address, avs_writedata} = '0;
      periph_flag = '0;
      periph_en = '1;
      rnd = 16'h0055;
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      bus(1'b0, ADDR_RESET_CONTROL_REG, 32'h0);
      chk("reset_control_reg reset", 32'h18, rd);
      bus(1'b1, 5'h02, 32'hffff_ffff);
      bus(1'b0, 5'h02, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, ADDR_WDT_EN, 32'h0);
      chk("wdt enable", 32'h1, rd);
      // Enabled flag already pending: the sleep instruction degrades to a no-op
      int_pin_flag <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sleep_go(16'h0100);
      chk("run nop", 1, core_run_reg);
      chk("wdclr nop", 0, n_wdc);
      bus(1'b0, ADDR_RESET_CONTROL_REG, 32'h0);
      chk("reset_control_reg nop", 32'h18, rd);
      int_pin_flag <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         pc = {rnd[15:1], 1'b0};
         port_out <= rnd[7:0];
         port_oe <= rnd[15:8];
         global_irq_enable <= rnd[0];
         v = n_vec;
         w = n_wdc;
         repeat (4) @(posedge sys_clk);
         sleep_go(pc);
         chk("run sleep", 0, core_run_reg);
         chk("osc sleep", 0, osc_drive_en_reg);
         chk("wdclr", w + 1, n_wdc);
         chk("prefetch", pc + 16'h2, pf_addr);
         bus(1'b0, ADDR_RESET_CONTROL_REG, 32'h0);
         chk("reset_control_reg sleep", 32'h10, rd);
         port_out <= ~rnd[7:0];
         port_oe <= ~rnd[15:8];
         periph_flag[PER_TIMER_ONE] <= 1'b1;
         repeat (20) @(posedge sys_clk);
         chk("sync timer", 0, core_run_reg);
         chk("port out", rnd[7:0], port_out_reg);
         chk("port oe", rnd[15:8], port_oe_reg);
         case (i)
            0: int_pin_flag <= 1'b1;
            1: port_b_change_flag <= 1'b1;
            default: timer_one_async <= 1'b1;
         endcase
         wake_chk;
         repeat (4) @(posedge sys_clk);
         chk("vector", v + rnd[0], n_vec);
         chk("no reset", 0, n_rst);
         bus(1'b1, ADDR_MASK, 32'h2);
         repeat (2) @(posedge sys_clk);
         chk("irq on", 1, irq_reg);
         {int_pin_flag, port_b_change_flag, timer_one_async} <= 3'h0;
         periph_flag <= '0;
         bus(1'b0, ADDR_STATUS, 32'h0);
         chk("status", 32'h3, rd);
         bus(1'b1, ADDR_STATUS, 32'hf);
         repeat (2) @(posedge sys_clk);
         chk("irq off", 0, irq_reg);
      end
      wdt_run <= 1'b1;
      sleep_go(16'h0200);
      chk("run wdt", 0, core_run_reg);
      wake_chk;
      wdt_run <= 1'b0;
      bus(1'b0, ADDR_RESET_CONTROL_REG, 32'h0);
      chk("reset_control_reg wdt", 32'h0, rd);
      chk("wdt no reset", 0, n_rst);
      sleep_go(16'h0300);
      master_clear_pin_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("pin reset", 1, n_rst);
      master_clear_pin_n <= 1'b1;
      end_of_test;
   end
   initial begin
      #400000;
      give_up;
   end
endmodule : sleep_wakeup_control_tb_top
